/* File: verilog/ipa_defs.svh */
// Offsets, field positions, reset values and timing of the pending arbiter
`ifndef IPA_DEFS_SVH
`define IPA_DEFS_SVH

`define IPA_ADDR_W 12
`define IPA_OFF_SRC_PEND 12'h000
`define IPA_OFF_MODE 12'h004
`define IPA_OFF_MASK 12'h008
`define IPA_OFF_PRIO 12'h00c
`define IPA_OFF_GRANT_PEND 12'h010
`define IPA_OFF_OFFSET 12'h014

`define IPA_RST_PEND 32'h00000000
`define IPA_RST_MODE 32'h00000000
`define IPA_RST_MASK 32'hffffffff
`define IPA_RST_PRIO 21'h000000
`define IPA_RST_SEL 2'h0

`define IPA_PRIO_MODE_LSB 0
`define IPA_PRIO_SEL_LSB 7

`define IPA_BIT_EXT_4_7 4
`define IPA_BIT_EXT_8_23 5
`define IPA_BIT_SERIAL_2 15
`define IPA_BIT_SERIAL_1 23
`define IPA_BIT_SERIAL_0 28

`define IPA_NUM_ARB 7
`define IPA_ANSWER_CYCLES 1

`endif

/* File: verilog/ipa_pkg.sv */
// Types shared by the pending arbiter and its rotating arbiters
package ipa_pkg;

  typedef struct packed {
    logic valid;
    logic [2:0] idx;
  } ipa_grant_t;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } ipa_bus_req_t;

endpackage : ipa_pkg

/* File: verilog/ipa_arbiter.sv */
// Six-input rotating priority arbiter
`timescale 1ns/10ps
`include "ipa_defs.svh"

module ipa_arbiter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] req,
  input wire logic rotate_en,
  input wire logic sel_wr,
  input wire logic [1:0] sel_wdata,
  input wire logic serviced,
  output ipa_pkg::ipa_grant_t grant,
  output logic [1:0] sel_q
);

  // Input 0 first, input 5 last, 1..4 rotated by the select
  always_comb begin
    logic [1:0] r;
    logic [2:0] pos;
    r = 2'h0;
    pos = 3'h0;
    grant = '0;
    if (req[5]) begin
      grant.valid = 1'b1;
      grant.idx = 3'h5;
    end
    for (int j = 3; j >= 0; j--) begin
      r = sel_q + 2'(j);
      pos = {1'b0, r} + 3'h1;
      if (req[pos]) begin
        grant.valid = 1'b1;
        grant.idx = pos;
      end
    end
    if (req[0]) begin
      grant.valid = 1'b1;
      grant.idx = 3'h0;
    end
  end

  // Serviced input 1..4 becomes the lowest of the rotating group
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= `IPA_RST_SEL;
    end else if (sel_wr) begin
      sel_q <= sel_wdata;
    end else if (serviced && rotate_en && grant.idx != 3'h0 &&
                 grant.idx != 3'h5) begin
      sel_q <= grant.idx[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_serv_one;
    serviced && rotate_en && !sel_wr && grant.idx == 3'h1;
  endsequence

  sequence s_serv_four;
    serviced && rotate_en && !sel_wr && grant.idx == 3'h4;
  endsequence

  a_rotate_one: assert property (@(posedge pclk) disable iff (!presetn)
    s_serv_one |=> sel_q == 2'h1)
    else $error("select not 01 after input 1 serviced");

  a_rotate_four: assert property (@(posedge pclk) disable iff (!presetn)
    s_serv_four |=> sel_q == 2'h0)
    else $error("select not 00 after input 4 serviced");

  a_fixed_order: assert property (@(posedge pclk) disable iff (!presetn)
    (!rotate_en && !sel_wr) |=> $stable(sel_q))
    else $error("select moved in fixed mode");

  a_input_zero: assert property (@(posedge pclk) disable iff (!presetn)
    req[0] |-> grant.valid && grant.idx == 3'h0)
    else $error("input zero did not win");

  a_input_five: assert property (@(posedge pclk) disable iff (!presetn)
    (req[5] && req[4:1] != 4'h0) |-> grant.idx != 3'h5)
    else $error("input five beat another request");

endmodule : ipa_arbiter

/* File: verilog/ipa_top.sv */
// Interrupt pending arbiter with APB register access
// Operation
// - Accept requests from 61 lines: 32 source, 9 serial, 20 pin
// - OR serial and pin groups onto shared inputs
// - Drive normal request after arbitration, fast request straight from pending
// - Record arbitration winner in granted pending
// - Per-source mode picks fast or normal
// - Request sets source bit; one granted bit
// - Masked source pends but never gets granted
// - Both pending registers clear by writing one
// - Mask one blocks service, zero allows it
// - Six first-level arbiters feed one second-level
// - Input zero first, five last, select rotates
// - Rotate mode loads select from serviced input 1..4
// - Source pending holds 32 per-source bits
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "ipa_defs.svh"

module ipa_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] src_req,
  input wire logic [8:0] serial_port_channel_request,
  input wire logic [19:0] external_pin_request,
  output logic fast_interrupt_request,
  output logic normal_interrupt_request
);

  ////////////////////////////////////////////////////////////////////////////
  // Source mapping of each arbiter input, -1 where unused
  function automatic int src_index(input int k, input int i);
    int b;
    b = -1;
    if (k == 0) begin
      if (i >= 1 && i <= 4) begin
        b = i - 1;
      end
    end else if (k == 5) begin
      if (i >= 1 && i <= 4) begin
        b = 27 + i;
      end
    end else begin
      b = 6 * k - 2 + i;
    end
    return b;
  endfunction : src_index

  function automatic logic [5:0] arb_req(input logic [31:0] c, input int k);
    logic [5:0] r;
    int b;
    r = 6'h00;
    b = 0;
    for (int i = 0; i < 6; i++) begin
      b = src_index(k, i);
      if (b >= 0) begin
        r[i] = c[b];
      end
    end
    return r;
  endfunction : arb_req

  ////////////////////////////////////////////////////////////////////////////
  ipa_pkg::ipa_bus_req_t bus;
  logic [31:0] merged;
  logic [31:0] source_pending_reg_q;
  logic [31:0] mode_q;
  logic [31:0] mask_q;
  logic [31:0] granted_pending_reg_q;
  logic [20:0] prio_q;
  logic [4:0] offset_q;
  logic [31:0] irq_cand;
  logic [31:0] fiq_cand;
  logic [31:0] rdata;
  logic hit;
  logic wr_en;
  logic wr_src;
  logic wr_int;
  logic wr_prio;
  logic take;
  logic [2:0] win_k;
  logic [2:0] win_i;
  logic [4:0] win_src;
  logic [31:0] win_onehot;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic fiq_q;
  logic irq_q;
  ipa_pkg::ipa_grant_t grant [`IPA_NUM_ARB];
  logic [1:0] sel [`IPA_NUM_ARB];
  logic [6:0] serviced;
  logic [6:0] mode_bits_q;

  assign bus = '{addr: paddr, write: pwrite, wdata: pwdata};

  ////////////////////////////////////////////////////////////////////////////
  // Group requests are ORed onto their shared inputs
  always_comb begin
    merged = src_req;
    merged[`IPA_BIT_SERIAL_0] = src_req[`IPA_BIT_SERIAL_0] |
      (|serial_port_channel_request[2:0]);
    merged[`IPA_BIT_SERIAL_1] = src_req[`IPA_BIT_SERIAL_1] |
      (|serial_port_channel_request[5:3]);
    merged[`IPA_BIT_SERIAL_2] = src_req[`IPA_BIT_SERIAL_2] |
      (|serial_port_channel_request[8:6]);
    merged[`IPA_BIT_EXT_4_7] = src_req[`IPA_BIT_EXT_4_7] |
      (|external_pin_request[3:0]);
    merged[`IPA_BIT_EXT_8_23] = src_req[`IPA_BIT_EXT_8_23] |
      (|external_pin_request[19:4]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB: zero-wait access, answer prepared in the setup cycle
  assign wr_en = psel && penable && bus.write && pready_q;
  assign wr_src = wr_en && bus.addr == `IPA_OFF_SRC_PEND;
  assign wr_int = wr_en && bus.addr == `IPA_OFF_GRANT_PEND;
  assign wr_prio = wr_en && bus.addr == `IPA_OFF_PRIO;

  always_comb begin
    hit = 1'b1;
    rdata = 32'h00000000;
    unique case (bus.addr)
      `IPA_OFF_SRC_PEND: rdata = source_pending_reg_q;
      `IPA_OFF_MODE: rdata = mode_q;
      `IPA_OFF_MASK: rdata = mask_q;
      `IPA_OFF_PRIO: rdata = {11'h000, prio_q};
      `IPA_OFF_GRANT_PEND: rdata = granted_pending_reg_q;
      `IPA_OFF_OFFSET: rdata = {27'h0000000, offset_q};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (psel && !penable) begin
      pready_q <= 1'b1;
      pslverr_q <= !hit;
      prdata_q <= bus.write ? 32'h00000000 : rdata;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `IPA_RST_MODE;
      mask_q <= `IPA_RST_MASK;
    end else if (wr_en && bus.addr == `IPA_OFF_MODE) begin
      mode_q <= bus.wdata;
    end else if (wr_en && bus.addr == `IPA_OFF_MASK) begin
      mask_q <= bus.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source pending: request sets, written ones clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_pending_reg_q <= `IPA_RST_PEND;
    end else begin
      source_pending_reg_q <= (source_pending_reg_q & ~(wr_src ? bus.wdata : 32'h00000000)) |
        merged;
    end
  end

  assign irq_cand = source_pending_reg_q & ~mask_q & ~mode_q;
  assign fiq_cand = source_pending_reg_q & ~mask_q & mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // Arbiters 0..5 take sources, arbiter 6 takes their winners
  genvar k;
  generate
    for (k = 0; k < `IPA_NUM_ARB; k++) begin : g_arb
      logic [5:0] req_k;
      if (k < 6) begin : g_first
        assign req_k = arb_req(irq_cand, k);
      end else begin : g_second
        assign req_k = {grant[5].valid, grant[4].valid, grant[3].valid,
          grant[2].valid, grant[1].valid, grant[0].valid};
      end
      assign serviced[k] = take && (k == 6 || int'(win_k) == k);
      ipa_arbiter u_arb (
        .pclk(pclk),
        .presetn(presetn),
        .req(req_k),
        .rotate_en(prio_q[`IPA_PRIO_MODE_LSB + k]),
        .sel_wr(wr_prio),
        .sel_wdata(bus.wdata[`IPA_PRIO_SEL_LSB + 2 * k +: 2]),
        .serviced(serviced[k]),
        .grant(grant[k]),
        .sel_q(sel[k])
      );
    end
  endgenerate

  // Priority register reads back the live selects
  always_comb begin
    prio_q[6:0] = 7'h00;
    prio_q[20:7] = 14'h0000;
    for (int m = 0; m < `IPA_NUM_ARB; m++) begin
      prio_q[`IPA_PRIO_SEL_LSB + 2 * m +: 2] = sel[m];
    end
    prio_q[6:0] = mode_bits_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_bits_q <= 7'(`IPA_RST_PRIO);
    end else if (wr_prio) begin
      mode_bits_q <= bus.wdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Granted pending: one bit, only loaded while empty
  assign take = granted_pending_reg_q == 32'h00000000 && grant[6].valid;
  assign win_k = grant[6].idx;
  assign win_i = grant[win_k].idx;
  assign win_src = 5'(src_index(int'(win_k), int'(win_i)));
  assign win_onehot = 32'h00000001 << win_src;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      granted_pending_reg_q <= `IPA_RST_PEND;
      offset_q <= 5'h00;
    end else if (take) begin
      granted_pending_reg_q <= win_onehot;
      offset_q <= win_src;
    end else if (wr_int) begin
      granted_pending_reg_q <= granted_pending_reg_q & ~bus.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request lines toward the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fiq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      fiq_q <= |fiq_cand;
      irq_q <= |(granted_pending_reg_q & ~mask_q & ~mode_q);
    end
  end

  assign fast_interrupt_request = fiq_q;
  assign normal_interrupt_request = irq_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  a_source_set: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> ((source_pending_reg_q & $past(merged)) == $past(merged)))
    else $error("request did not set source pending");

  a_source_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_src |=> ((source_pending_reg_q & $past(pwdata) & ~$past(merged)) == 32'h0))
    else $error("written one did not clear source pending");

  a_grant_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot0(granted_pending_reg_q))
    else $error("granted pending has more than one bit");

  a_grant_load: assert property (@(posedge pclk) disable iff (!presetn)
    (granted_pending_reg_q == 32'h0 && irq_cand != 32'h0) |=> $onehot(granted_pending_reg_q))
    else $error("unmasked request not granted");

  a_masked_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (granted_pending_reg_q == 32'h0 && irq_cand == 32'h0) |=> granted_pending_reg_q == 32'h0)
    else $error("granted pending set without candidate");

  a_grant_cause: assert property (@(posedge pclk) disable iff (!presetn)
    (granted_pending_reg_q == 32'h0 ##1 granted_pending_reg_q != 32'h0) |->
      (granted_pending_reg_q & $past(irq_cand)) != 32'h0)
    else $error("granted bit was not an unmasked request");

  a_normal_line: assert property (@(posedge pclk) disable iff (!presetn)
    (granted_pending_reg_q & ~mask_q & ~mode_q) != 32'h0 |=> normal_interrupt_request)
    else $error("normal request not raised");

  a_normal_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (granted_pending_reg_q & ~mask_q & ~mode_q) == 32'h0 |=> !normal_interrupt_request)
    else $error("normal request stuck high");

  a_fast_line: assert property (@(posedge pclk) disable iff (!presetn)
    fiq_cand != 32'h0 |=> fast_interrupt_request)
    else $error("fast request not raised");

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> pready ##1 !pready)
    else $error("register answer not in one cycle");

  a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (s_setup and !hit) |=> pslverr)
    else $error("unmapped access without error");

endmodule : ipa_top

/* File: verification/ipa_core_model.sv */
// Processor core model that takes the fast and normal request lines
`timescale 1ns/10ps
module ipa_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fast_line,
  input wire logic normal_line,
  input wire logic fast_disable,
  input wire logic normal_disable,
  output logic fast_entered_q,
  output logic normal_entered_q
);
  // A line is taken only while its disable flag is clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_entered_q <= 1'b0;
      normal_entered_q <= 1'b0;
    end else begin
      fast_entered_q <= fast_line & ~fast_disable;
      normal_entered_q <= normal_line & ~normal_disable;
    end
  end
endmodule : ipa_core_model

/* File: verification/tb_interrupt_pending_arbiter.sv */
// Register-level tests of the pending arbiter with a core model
`timescale 1ns/10ps
`include "ipa_defs.svh"
module tb_interrupt_pending_arbiter;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, fiq_l, irq_l, f_in, n_in;
  logic [31:0] src_req = 32'h00000000;
  logic [8:0] ser = 9'h000;
  logic [19:0] ext = 20'h00000;
  logic f_dis = 1'b0;
  logic n_dis = 1'b1;
  logic [31:0] rdata;
  logic rerr;
  int num_errors = 0;
  int tests_run = 0;

  always #5 pclk = ~pclk;

  ipa_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_req(src_req), .serial_port_channel_request(ser),
    .external_pin_request(ext), .fast_interrupt_request(fiq_l),
    .normal_interrupt_request(irq_l));

  ipa_core_model core (.pclk(pclk), .presetn(presetn), .fast_line(fiq_l),
    .normal_line(irq_l), .fast_disable(f_dis), .normal_disable(n_dis),
    .fast_entered_q(f_in), .normal_entered_q(n_in));

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk("read data", exp, rdata);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Pulse the request inputs for one cycle, then let the walk finish
  task automatic pulse(input logic [31:0] s, input logic [8:0] u,
                       input logic [19:0] e);
    @(posedge pclk);
    src_req <= s;
    ser <= u;
    ext <= e;
    @(posedge pclk);
    src_req <= 32'h00000000;
    ser <= 9'h000;
    ext <= 20'h00000;
    repeat (3) @(posedge pclk);
  endtask : pulse

  initial begin
    #200us;
    num_errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    chk("lines", 32'h0, {30'h0, fiq_l, irq_l});
    rd(`IPA_OFF_SRC_PEND, 32'h00000000);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000000);
    rd(`IPA_OFF_MASK, 32'hffffffff);
    rd(12'h040, 32'h00000000);
    chk("slave error", 32'h1, {31'h0, rerr});
    $display("test reset done");

    pulse(32'h00000080, 9'h000, 20'h00000);
    rd(`IPA_OFF_SRC_PEND, 32'h00000080);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000000);
    wr(`IPA_OFF_MASK, 32'hffffff7f);
    repeat (3) @(posedge pclk);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000080);
    rd(`IPA_OFF_OFFSET, 32'h00000007);
    chk("normal line", 32'h1, {31'h0, irq_l});
    chk("core entry held", 32'h0, {31'h0, n_in});
    @(posedge pclk);
    n_dis <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("core entry", 32'h1, {31'h0, n_in});
    wr(`IPA_OFF_SRC_PEND, 32'h00000080);
    wr(`IPA_OFF_GRANT_PEND, 32'h00000080);
    repeat (3) @(posedge pclk);
    rd(`IPA_OFF_SRC_PEND, 32'h00000000);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000000);
    chk("normal line", 32'h0, {31'h0, irq_l});
    wr(`IPA_OFF_MASK, 32'hffffffff);
    $display("test masked and normal done");

    // Each merged group lands on its shared source bit
    pulse(32'h0, 9'h004, 20'h00000);
    rd(`IPA_OFF_SRC_PEND, 32'h10000000);
    pulse(32'h0, 9'h020, 20'h00000);
    rd(`IPA_OFF_SRC_PEND, 32'h10800000);
    pulse(32'h0, 9'h100, 20'h00001);
    rd(`IPA_OFF_SRC_PEND, 32'h10808010);
    pulse(32'h0, 9'h000, 20'h80000);
    rd(`IPA_OFF_SRC_PEND, 32'h10808030);
    wr(`IPA_OFF_SRC_PEND, 32'hffffffff);
    rd(`IPA_OFF_SRC_PEND, 32'h00000000);
    $display("test merge done");

    wr(`IPA_OFF_MODE, 32'h00000080);
    wr(`IPA_OFF_MASK, 32'hffffff7f);
    f_dis <= 1'b1;
    pulse(32'h00000080, 9'h000, 20'h00000);
    chk("fast line", 32'h1, {31'h0, fiq_l});
    chk("normal line", 32'h0, {31'h0, irq_l});
    chk("core fast held", 32'h0, {31'h0, f_in});
    f_dis <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("core fast entry", 32'h1, {31'h0, f_in});
    rd(`IPA_OFF_GRANT_PEND, 32'h00000000);
    wr(`IPA_OFF_SRC_PEND, 32'h00000080);
    repeat (3) @(posedge pclk);
    chk("fast line", 32'h0, {31'h0, fiq_l});
    wr(`IPA_OFF_MODE, 32'h00000000);
    $display("test fast done");

    wr(`IPA_OFF_MASK, 32'h00000000);
    wr(`IPA_OFF_PRIO, 32'h00000002);
    pulse(32'h00000230, 9'h000, 20'h00000);
    rd(`IPA_OFF_SRC_PEND, 32'h00000230);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000010);
    rd(`IPA_OFF_PRIO, 32'h00000002);
    wr(`IPA_OFF_SRC_PEND, 32'h00000010);
    wr(`IPA_OFF_GRANT_PEND, 32'h00000010);
    repeat (3) @(posedge pclk);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000020);
    rd(`IPA_OFF_PRIO, 32'h00000202);
    wr(`IPA_OFF_SRC_PEND, 32'h00000020);
    wr(`IPA_OFF_GRANT_PEND, 32'h00000020);
    repeat (3) @(posedge pclk);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000200);
    rd(`IPA_OFF_PRIO, 32'h00000202);
    wr(`IPA_OFF_SRC_PEND, 32'h00000200);
    wr(`IPA_OFF_GRANT_PEND, 32'h00000200);
    pulse(32'h00000060, 9'h000, 20'h00000);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000040);
    rd(`IPA_OFF_PRIO, 32'h00000402);
    wr(`IPA_OFF_SRC_PEND, 32'h00000060);
    wr(`IPA_OFF_GRANT_PEND, 32'h00000040);
    pulse(32'h00000100, 9'h000, 20'h00000);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000100);
    rd(`IPA_OFF_PRIO, 32'h00000002);
    wr(`IPA_OFF_SRC_PEND, 32'h00000100);
    wr(`IPA_OFF_GRANT_PEND, 32'h00000100);
    repeat (3) @(posedge pclk);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000000);
    chk("normal line", 32'h0, {31'h0, irq_l});
    $display("test priority done");

    // Reset in mid-run drops pending state, settings and lines
    pulse(32'h00000001, 9'h000, 20'h00000);
    chk("normal line", 32'h1, {31'h0, irq_l});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("lines", 32'h0, {30'h0, fiq_l, irq_l});
    rd(`IPA_OFF_SRC_PEND, 32'h00000000);
    rd(`IPA_OFF_GRANT_PEND, 32'h00000000);
    rd(`IPA_OFF_PRIO, 32'h00000000);
    rd(`IPA_OFF_MASK, 32'hffffffff);
    $display("test reset in run done");
    complete_run();
  end
endmodule : tb_interrupt_pending_arbiter
